// >>> pkg/sensor_ctrl_consts.svh
// Constants for the sensor mode and reset controller
`ifndef SENSOR_CTRL_CONSTS_SVH
`define SENSOR_CTRL_CONSTS_SVH
`define CLK_FREQ_HZ 10000000
`define DEV_ADDR 7'h44
`define GC_ADDR 7'h00
`define GC_RESET_BYTE 8'h06
`define CMD_FAST_RESP 16'h2b32
`define CMD_FETCH 16'he000
`define CMD_SOFT_RESET 16'h30a2
`define CMD_BREAK_DEF 16'h3093
`define CMD_HEAT_ON_DEF 16'h306d
`define CMD_HEAT_OFF_DEF 16'h3066
`define BREAK_TIME_US 1000
`define BREAK_CYCLES (`BREAK_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define RST_PIN_MIN_NS 1000
`define RST_PIN_CYCLES ((`RST_PIN_MIN_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define RESET_BUSY_CYCLES 16
`define FAST_RESP_HZ 4
`define ACQ_PERIOD_CYCLES (`CLK_FREQ_HZ / `FAST_RESP_HZ)
`define RECOVERY_CLOCKS 9
`define STAT_HEATER_BIT 13
`endif

// >>> pkg/sensor_ctrl_pkg.sv
// Types for the sensor mode and reset controller
package sensor_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_PERIODIC = 2'b01,
    MODE_STOPPING = 2'b11,
    MODE_RESET = 2'b10
  } mode_t;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_ADDR = 3'b001,
    LK_ADDR_ACK = 3'b011,
    LK_BYTE = 3'b010,
    LK_BYTE_ACK = 3'b110,
    LK_READ_ACK = 3'b111,
    LK_SKIP = 3'b101
  } link_t;
endpackage

// >>> core/link_sync.sv
// Two-stage synchroniser and edge finder for link pins
`timescale 1ns/1ns
module link_sync (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;
  assign o_fall = ~sync_q & last_q;
endmodule

// >>> core/sensor_mode_reset_control.sv
// Command decoder, mode control and reset control of the sensor
//
// Summary of operation
// - Fast-response command starts 4 Hz acquisition
// - Same write header and 16-bit framing
// - Break aborts, returns single-shot within 1 ms
// - Commands ignored while a reset runs
// - Full reset at power-up
// - Nine SCL clocks, SDA high, idle interface
// - Recovery resets interface, keeps status
// - Soft reset reloads calibration, resets controller
// - Calibration reloaded in the same cycle as each measurement start
// - General call 0x00 then 0x06 resets
// - General call honoured only when accepting commands
// - Reset pin low one microsecond resets
// - Heater commands switch heater, status shows
// - Heater off after any reset except bus recovery
// - Acknowledged read header clears measurement data memory
// - Read header NACKed when no data
`timescale 1ns/1ns
`include "sensor_ctrl_consts.svh"
module sensor_mode_reset_control #(
  parameter logic [15:0] CMD_BREAK = `CMD_BREAK_DEF,
  parameter logic [15:0] CMD_HEAT_ON = `CMD_HEAT_ON_DEF,
  parameter logic [15:0] CMD_HEAT_OFF = `CMD_HEAT_OFF_DEF,
  parameter int ACQ_PERIOD = `ACQ_PERIOD_CYCLES,
  parameter int BREAK_TIME = `BREAK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_external_reset_pin_active_low,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_periodic,
  output logic o_heater,
  output logic o_data_ready,
  output logic o_cal_reload,
  output logic o_measure_start,
  output logic o_busy,
  output logic [15:0] o_status
);
  ////////////////////////////////////////////////////////////////////////////
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic rst_pin;
  link_sync u_scl (.i_clock(i_clock), .i_rst(i_rst), .i_async(i_scl),
    .o_level(scl), .o_rise(scl_rise), .o_fall(scl_fall));
  link_sync u_sda (.i_clock(i_clock), .i_rst(i_rst), .i_async(i_sda),
    .o_level(sda), .o_rise(sda_rise), .o_fall(sda_fall));
  link_sync u_rst (.i_clock(i_clock), .i_rst(i_rst), .i_async(i_external_reset_pin_active_low),
    .o_level(rst_pin), .o_rise(), .o_fall());
  wire start_cond = sda_fall & scl;
  wire stop_cond = sda_rise & scl;
  ////////////////////////////////////////////////////////////////////////////
  // Link byte engine
  sensor_ctrl_pkg::link_t lk_q, lk_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] rec_q, rec_d;
  logic [7:0] msb_q, msb_d;
  logic nbyte_q, nbyte_d;
  logic gc_q, gc_d;
  logic ack_q, ack_d;
  logic sda_oe_q, sda_oe_d;
  logic cmd_v_q, cmd_v_d;
  logic [15:0] cmd_q, cmd_d;
  logic gc_rst_q, gc_rst_d;
  logic read_q, read_d;
  logic busy;
  always_comb begin
    lk_d = lk_q;
    sh_d = sh_q;
    bit_d = bit_q;
    rec_d = rec_q;
    msb_d = msb_q;
    nbyte_d = nbyte_q;
    gc_d = gc_q;
    ack_d = ack_q;
    sda_oe_d = sda_oe_q;
    cmd_v_d = 1'b0;
    cmd_d = cmd_q;
    gc_rst_d = 1'b0;
    read_d = 1'b0;
    // Count SCL clocks with SDA high for bus recovery
    // Our own ACK also counts as released data, else recovery stalls on it
    if (scl_rise) begin
      rec_d = (sda || sda_oe_q) ? ((rec_q == 4'hf) ? rec_q : rec_q + 4'h1) : 4'h0;
    end
    if (start_cond) begin
      lk_d = sensor_ctrl_pkg::LK_ADDR;
      bit_d = 4'h0;
      nbyte_d = 1'b0;
      sda_oe_d = 1'b0;
      rec_d = 4'h0;
    end else if (stop_cond || rec_q >= 4'(`RECOVERY_CLOCKS)) begin
      // Only the link state is cleared; status stays untouched
      lk_d = sensor_ctrl_pkg::LK_IDLE;
      sda_oe_d = 1'b0;
      rec_d = 4'h0;
    end else begin
      case (lk_q)
        sensor_ctrl_pkg::LK_ADDR, sensor_ctrl_pkg::LK_BYTE: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (lk_q == sensor_ctrl_pkg::LK_ADDR) begin
              gc_d = (sh_q[7:1] == `GC_ADDR) && !sh_q[0];
              // Read header needs data present, else NACK
              ack_d = !busy && ((sh_q[7:1] == `DEV_ADDR && (!sh_q[0] || o_data_ready))
                || (sh_q[7:1] == `GC_ADDR && !sh_q[0]));
              read_d = (sh_q[7:1] == `DEV_ADDR) && sh_q[0] && !busy && o_data_ready;
              lk_d = sensor_ctrl_pkg::LK_ADDR_ACK;
            end else begin
              ack_d = 1'b1;
              if (gc_q) begin
                gc_rst_d = (sh_q == `GC_RESET_BYTE);
              end else if (nbyte_q) begin
                cmd_d = {msb_q, sh_q};
                cmd_v_d = 1'b1;
              end else begin
                msb_d = sh_q;
              end
              nbyte_d = ~nbyte_q;
              lk_d = sensor_ctrl_pkg::LK_BYTE_ACK;
            end
            sda_oe_d = ack_d;
          end
        end
        sensor_ctrl_pkg::LK_ADDR_ACK, sensor_ctrl_pkg::LK_BYTE_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            if (!ack_q) begin
              lk_d = sensor_ctrl_pkg::LK_SKIP;
            end else if (lk_q == sensor_ctrl_pkg::LK_ADDR_ACK && sh_q[0]) begin
              // Data serialiser lives elsewhere; this block stays off the bus
              lk_d = sensor_ctrl_pkg::LK_SKIP;
            end else begin
              lk_d = sensor_ctrl_pkg::LK_BYTE;
            end
          end
        end
        sensor_ctrl_pkg::LK_IDLE, sensor_ctrl_pkg::LK_SKIP, sensor_ctrl_pkg::LK_READ_ACK: begin
          sda_oe_d = 1'b0;
        end
        default: begin
          lk_d = sensor_ctrl_pkg::LK_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lk_q <= sensor_ctrl_pkg::LK_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      rec_q <= 4'h0;
      msb_q <= 8'h00;
      nbyte_q <= 1'b0;
      gc_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cmd_v_q <= 1'b0;
      cmd_q <= 16'h0000;
      gc_rst_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      lk_q <= lk_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      rec_q <= rec_d;
      msb_q <= msb_d;
      nbyte_q <= nbyte_d;
      gc_q <= gc_d;
      ack_q <= ack_d;
      sda_oe_q <= sda_oe_d;
      cmd_v_q <= cmd_v_d;
      cmd_q <= cmd_d;
      gc_rst_q <= gc_rst_d;
      read_q <= read_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Mode and reset control
  sensor_ctrl_pkg::mode_t mode_q, mode_d;
  logic [31:0] tmr_q, tmr_d;
  logic [3:0] pin_cnt_q, pin_cnt_d;
  logic heater_q, heater_d;
  logic ready_q, ready_d;
  logic cal_q, cal_d;
  logic meas_q, meas_d;
  logic periodic_q, periodic_d;
  logic busy_q, busy_d;
  assign busy = busy_q;
  always_comb begin
    mode_d = mode_q;
    tmr_d = tmr_q;
    pin_cnt_d = rst_pin ? 4'h0 : ((pin_cnt_q == 4'hf) ? pin_cnt_q : pin_cnt_q + 4'h1);
    heater_d = heater_q;
    ready_d = ready_q;
    cal_d = 1'b0;
    meas_d = 1'b0;
    if (pin_cnt_q >= 4'(`RST_PIN_CYCLES) || gc_rst_q) begin
      mode_d = sensor_ctrl_pkg::MODE_RESET;
      tmr_d = 32'(`RESET_BUSY_CYCLES);
      heater_d = 1'b0;
      ready_d = 1'b0;
    end else begin
      // Clear comes first so a new acquisition in the same cycle wins
      if (read_q) begin
        ready_d = 1'b0;
      end
      case (mode_q)
        sensor_ctrl_pkg::MODE_RESET: begin
          if (tmr_q != 32'h0) begin
            tmr_d = tmr_q - 32'h1;
          end else begin
            mode_d = sensor_ctrl_pkg::MODE_SINGLE;
            cal_d = 1'b1;
          end
        end
        sensor_ctrl_pkg::MODE_STOPPING: begin
          if (tmr_q > 32'h1) begin
            tmr_d = tmr_q - 32'h1;
          end else begin
            mode_d = sensor_ctrl_pkg::MODE_SINGLE;
          end
        end
        sensor_ctrl_pkg::MODE_PERIODIC: begin
          if (tmr_q > 32'h1) begin
            tmr_d = tmr_q - 32'h1;
          end else begin
            tmr_d = 32'(ACQ_PERIOD);
            meas_d = 1'b1;
            cal_d = 1'b1;
            ready_d = 1'b1;
          end
        end
        default: begin
          mode_d = sensor_ctrl_pkg::MODE_SINGLE;
        end
      endcase
      if (cmd_v_q && mode_q != sensor_ctrl_pkg::MODE_RESET) begin
        if (cmd_q == `CMD_SOFT_RESET) begin
          mode_d = sensor_ctrl_pkg::MODE_RESET;
          tmr_d = 32'(`RESET_BUSY_CYCLES);
          heater_d = 1'b0;
          ready_d = 1'b0;
          meas_d = 1'b0;
        end else if (cmd_q == CMD_BREAK) begin
          mode_d = sensor_ctrl_pkg::MODE_STOPPING;
          tmr_d = 32'(BREAK_TIME);
          meas_d = 1'b0;
        end else if (cmd_q == `CMD_FAST_RESP) begin
          mode_d = sensor_ctrl_pkg::MODE_PERIODIC;
          tmr_d = 32'(ACQ_PERIOD);
        end else if (cmd_q == CMD_HEAT_ON) begin
          heater_d = 1'b1;
        end else if (cmd_q == CMD_HEAT_OFF) begin
          heater_d = 1'b0;
        end
      end
    end
    periodic_d = (mode_d == sensor_ctrl_pkg::MODE_PERIODIC);
    busy_d = (mode_d == sensor_ctrl_pkg::MODE_RESET);
  end
  // Power-up reset lands in the reset state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= sensor_ctrl_pkg::MODE_RESET;
      tmr_q <= 32'(`RESET_BUSY_CYCLES);
      pin_cnt_q <= 4'h0;
      heater_q <= 1'b0;
      ready_q <= 1'b0;
      cal_q <= 1'b0;
      meas_q <= 1'b0;
      periodic_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      tmr_q <= tmr_d;
      pin_cnt_q <= pin_cnt_d;
      heater_q <= heater_d;
      ready_q <= ready_d;
      cal_q <= cal_d;
      meas_q <= meas_d;
      periodic_q <= periodic_d;
      busy_q <= busy_d;
    end
  end
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_q;
  assign o_periodic = periodic_q;
  assign o_heater = heater_q;
  assign o_data_ready = ready_q;
  assign o_cal_reload = cal_q;
  assign o_measure_start = meas_q;
  assign o_busy = busy_q;
  assign o_status = {2'b00, heater_q, 13'h0000};
  ////////////////////////////////////////////////////////////////////////////
  property p_heater_reset;
    @(posedge i_clock) disable iff (i_rst) gc_rst_q |=> !heater_q && busy_q;
  endproperty
  a_heater_reset: assert property (p_heater_reset) else $error("heater on after reset");
  property p_break;
    @(posedge i_clock) disable iff (i_rst)
      (cmd_v_q && cmd_q == CMD_BREAK && !busy_q && !gc_rst_q && pin_cnt_q < 4'(`RST_PIN_CYCLES))
      |=> !periodic_q && mode_q == sensor_ctrl_pkg::MODE_STOPPING && tmr_q <= 32'(`BREAK_CYCLES);
  endproperty
  a_break: assert property (p_break) else $error("break did not stop periodic mode");
  property p_break_done;
    @(posedge i_clock) disable iff (i_rst)
      (mode_q == sensor_ctrl_pkg::MODE_STOPPING && tmr_q <= 32'h1 && !cmd_v_q && !gc_rst_q
      && pin_cnt_q < 4'(`RST_PIN_CYCLES)) |=> mode_q == sensor_ctrl_pkg::MODE_SINGLE;
  endproperty
  a_break_done: assert property (p_break_done) else $error("break did not reach single mode");
  property p_ignore_busy;
    @(posedge i_clock) disable iff (i_rst) busy_q && cmd_v_q && !gc_rst_q |=> $stable(heater_q);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("command taken during reset");
  property p_fetch_clear;
    @(posedge i_clock) disable iff (i_rst) read_q && !meas_d |=> !o_data_ready;
  endproperty
  a_fetch_clear: assert property (p_fetch_clear) else $error("data still ready after read");
  property p_recovery;
    @(posedge i_clock) disable iff (i_rst) rec_q >= 4'(`RECOVERY_CLOCKS) && !start_cond
      |=> lk_q == sensor_ctrl_pkg::LK_IDLE && !o_sda_oe;
  endproperty
  a_recovery: assert property (p_recovery) else $error("interface not idle after recovery");
  property p_status_kept;
    @(posedge i_clock) disable iff (i_rst) rec_q >= 4'(`RECOVERY_CLOCKS) && !gc_rst_q && !cmd_v_q
      && pin_cnt_q < 4'(`RST_PIN_CYCLES) |=> $stable(heater_q);
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("status changed by recovery");
  property p_pin_reset;
    @(posedge i_clock) disable iff (i_rst) pin_cnt_q >= 4'(`RST_PIN_CYCLES) |=> busy_q && !o_data_ready;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");
  property p_periodic_cal;
    @(posedge i_clock) disable iff (i_rst) meas_q |-> cal_q && periodic_q;
  endproperty
  a_periodic_cal: assert property (p_periodic_cal) else $error("measure without reload");
  c_periodic: cover property (@(posedge i_clock) disable iff (i_rst) meas_q);
  c_gc_reset: cover property (@(posedge i_clock) disable iff (i_rst) gc_rst_q);
  c_heater_on: cover property (@(posedge i_clock) disable iff (i_rst) $rose(heater_q));
endmodule

// >>> tb/i2c_master_model.sv
// Serial bus master model that faces the sensor controller
`timescale 1ns/1ns
module i2c_master_model (
  input wire logic i_clock,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Entered with the bus idle; also the start after recovery
  task automatic start_c();
    o_sda_low <= 1'b1;
    wait_clk(4);
    o_scl <= 1'b0;
    wait_clk(2);
  endtask
  // Data moves only mid low phase, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= ~b;
    wait_clk(2);
    o_scl <= 1'b1;
    wait_clk(4);
    r = i_sda_line;
    o_scl <= 1'b0;
    wait_clk(2);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic stop_c();
    o_sda_low <= 1'b1;
    wait_clk(2);
    o_scl <= 1'b1;
    wait_clk(4);
    o_sda_low <= 1'b0;
    wait_clk(4);
  endtask
  // Nine clocks with data released, link clock left high
  task automatic recover();
    o_sda_low <= 1'b0;
    repeat (9) begin
      wait_clk(2);
      o_scl <= 1'b1;
      wait_clk(4);
      o_scl <= 1'b0;
      wait_clk(2);
    end
    o_scl <= 1'b1;
    wait_clk(4);
  endtask
endmodule

// >>> tb/sensor_mode_reset_control_tb.sv
// Self-checking bench for the sensor mode and reset controller
`timescale 1ns/1ns
`include "sensor_ctrl_consts.svh"
module sensor_mode_reset_control_tb;
  localparam int ACQ = 2000;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic rst_pin_n = 1'b1;
  logic scl, sda_low, sda_o, sda_oe, periodic, heater, ready, cal, meas, busy, ack;
  logic [15:0] status;
  wire logic sda_line;
  int errors = 0;
  int total_checks = 0;
  int cal_cnt = 0;
  int cal_mark = 0;
  // Open drain with pull-up: high unless someone pulls low
  assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
  always #50 i_clock = ~i_clock;
  // Reload pulse lasts one cycle; count it where it is settled
  always @(negedge i_clock) begin
    if (cal === 1'b1) cal_cnt++;
  end
  sensor_mode_reset_control #(.ACQ_PERIOD(ACQ), .BREAK_TIME(50)) dut_u (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_scl(scl),
    .i_sda(sda_line),
    .i_external_reset_pin_active_low(rst_pin_n),
    .o_sda(sda_o),
    .o_sda_oe(sda_oe),
    .o_periodic(periodic),
    .o_heater(heater),
    .o_data_ready(ready),
    .o_cal_reload(cal),
    .o_measure_start(meas),
    .o_busy(busy),
    .o_status(status)
  );
  i2c_master_model master_u (
    .i_clock(i_clock),
    .i_sda_line(sda_line),
    .o_scl(scl),
    .o_sda_low(sda_low)
  );
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd_bytes(input logic [15:0] c, output logic a);
    logic a1;
    master_u.start_c();
    master_u.put_byte({`DEV_ADDR, 1'b0}, a);
    master_u.put_byte(c[15:8], a1);
    master_u.put_byte(c[7:0], a1);
  endtask
  task automatic cmd(input logic [15:0] c, output logic a);
    cmd_bytes(c, a);
    master_u.stop_c();
    repeat (5) @(posedge i_clock);
  endtask
  task automatic rd_hdr(output logic a);
    master_u.start_c();
    master_u.put_byte({`DEV_ADDR, 1'b1}, a);
    master_u.stop_c();
  endtask
  // Samples before the edge's updates, so a one-cycle pulse is seen once
  task automatic next_meas(output int n);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (meas !== 1'b1 && n < 3000);
  endtask
  task automatic wait_cal_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge i_clock);
      n++;
    end
    repeat (3) @(posedge i_clock);
    check(16'(cal_cnt - cal_mark), 16'h1);
    check(16'(busy), 16'h0);
    check(16'(heater), 16'h0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_power_up();
    repeat (3) @(posedge i_clock);
    check(16'(busy), 16'h1);
    i_rst <= 1'b0;
    wait_cal_idle();
    check(16'(periodic), 16'h0);
  endtask
  task automatic t_fast_fetch_break();
    int n;
    cmd(`CMD_FAST_RESP, ack);
    check(16'(ack), 16'h1);
    check(16'(periodic), 16'h1);
    next_meas(n);
    next_meas(n);
    check(16'(cal), 16'h1);
    check(16'(n), 16'(ACQ));
    repeat (3) @(posedge i_clock);
    check(16'(ready), 16'h1);
    cmd(`CMD_FETCH, ack);
    rd_hdr(ack);
    check(16'(ack), 16'h1);
    check(16'(ready), 16'h0);
    rd_hdr(ack);
    check(16'(ack), 16'h0);
    cmd(`CMD_BREAK_DEF, ack);
    check(16'(periodic), 16'h0);
    next_meas(n);
    check(16'(n), 16'd3000);
  endtask
  task automatic t_heater_recovery();
    cmd(`CMD_HEAT_ON_DEF, ack);
    check(16'(heater), 16'h1);
    check(16'(status[`STAT_HEATER_BIT]), 16'h1);
    master_u.start_c();
    master_u.put_byte({`DEV_ADDR, 1'b0}, ack);
    master_u.recover();
    check(16'(sda_line), 16'h1);
    check(16'(status[`STAT_HEATER_BIT]), 16'h1);
    cmd(`CMD_HEAT_OFF_DEF, ack);
    check(16'(ack), 16'h1);
    check(16'(heater), 16'h0);
  endtask
  // Busy lasts only a few cycles past the frame, so look before the stop
  task automatic t_soft_reset();
    cmd(`CMD_HEAT_ON_DEF, ack);
    cal_mark = cal_cnt;
    cmd_bytes(`CMD_SOFT_RESET, ack);
    check(16'(busy), 16'h1);
    master_u.stop_c();
    wait_cal_idle();
  endtask
  task automatic t_general_call();
    cmd(`CMD_HEAT_ON_DEF, ack);
    cal_mark = cal_cnt;
    master_u.start_c();
    master_u.put_byte({`GC_ADDR, 1'b0}, ack);
    check(16'(ack), 16'h1);
    master_u.put_byte(`GC_RESET_BYTE, ack);
    master_u.stop_c();
    check(16'(busy), 16'h1);
    wait_cal_idle();
  endtask
  // Pin held well past its minimum; a write header sent meanwhile must be NACKed
  task automatic t_pin_reset();
    cmd(`CMD_HEAT_ON_DEF, ack);
    cal_mark = cal_cnt;
    @(posedge i_clock);
    rst_pin_n <= 1'b0;
    repeat (20) @(posedge i_clock);
    check(16'(busy), 16'h1);
    check(16'(heater), 16'h0);
    master_u.start_c();
    master_u.put_byte({`DEV_ADDR, 1'b0}, ack);
    master_u.stop_c();
    check(16'(ack), 16'h0);
    rst_pin_n <= 1'b1;
    wait_cal_idle();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    t_power_up();
    t_fast_fetch_break();
    t_heater_recovery();
    t_soft_reset();
    t_general_call();
    t_pin_reset();
    conclude();
  end
  // Run needs about 1 ms; a hang is cut at 5 ms
  initial begin
    #5000000;
    errors++;
    conclude();
  end
endmodule
